// ==== bench/drs_chk_asserts.sv ====
// Purpose: port checks. Assumes: zero-wait apb. Notes: flags seen via reads
`timescale 1ns/1ps
`default_nettype none
module drs_chk (input wire logic clock, arst_n, psel, penable, pwrite,
    input wire logic pslverr, trigger_evt, fifo_full, fifo_capture,
    input wire logic run_start, run_armed, input wire logic [7:0] paddr,
    input wire logic [31:0] prdata);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    wire wr = psel && penable && pwrite;
    wire st = psel && penable && paddr == 8'h04;
    wire stop = trigger_evt || fifo_full || wr;
    wire rdz = !prdata[4] && prdata[31:8] == 24'h0;
    wire bad = psel && penable && paddr != 8'h00 && paddr != 8'h04;
    a_err_unmap: assert property (bad |-> pslverr)
        else $error("unmapped access not flagged");
    a_start_arm: assert property (run_start |=> run_armed)
        else $error("arm missing after start");
    a_start_new: assert property (run_start |-> !run_armed)
        else $error("start while armed");
    a_start_wr: assert property (run_start |-> wr && paddr == 8'h00)
        else $error("start without control write");
    a_arm_hold: assert property (run_armed && !stop |=> run_armed)
        else $error("arm dropped without cause");
    a_end_why: assert property ($fell(run_armed) |-> $past(stop))
        else $error("run ended without cause");
    a_rd_zero: assert property (st && !pwrite |-> rdz)
        else $error("unused status bits set");
    a_st_ok: assert property (st |-> !pslverr)
        else $error("status access flagged");
    a_cap_arm: assert property (fifo_capture |-> run_armed)
        else $error("capture while idle");
    cover property (run_start);
    cover property ($fell(run_armed));
    cover property (st && !pwrite);
endmodule // drs_chk
`default_nettype wire

// ==== bench/drs_debug_run_status_tb.sv ====
// Purpose: run status bench. Assumes: ctrl 0x00, status 0x04. Notes: apb only
`timescale 1ns/1ps
`default_nettype none
module drs_debug_run_status_tb;
    logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, drain = 0;
    logic comp_a_hit = 0, comp_b_hit = 0, trigger_evt = 0, pready, pslverr;
    logic fifo_full, fifo_capture, run_start, run_armed, err;
    logic [7:0] paddr = 0;
    logic [3:0] fifo_words;
    logic [31:0] pwdata = 0, prdata, rd;
    int error_cnt = 0, checks_done = 0;
    initial forever #2.5 clock = ~clock;
    drs_debug_run_status drs_debug_run_status_inst (.clock(clock),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .comp_a_hit(comp_a_hit), .comp_b_hit(comp_b_hit),
        .trigger_evt(trigger_evt), .fifo_full(fifo_full),
        .fifo_words(fifo_words), .fifo_capture(fifo_capture),
        .run_start(run_start), .run_armed(run_armed));
    drs_fifo_model drs_fifo_model_inst (.clock(clock), .arst_n(arst_n),
        .fifo_capture(fifo_capture), .run_start(run_start), .drain(drain),
        .fifo_words(fifo_words), .fifo_full(fifo_full));
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock) penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0; @(posedge clock);
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin error_cnt++;
            $display("ERROR %0t seen %h exp %h", $time, s, e); end
    endtask
    task rs(input logic [31:0] e); apb(0, 8'h04, 0); chk(rd, e); endtask
    // one-cycle pulse: 0 comparator a, 1 comparator b, 2 trigger
    task pulse(input int k);
        comp_a_hit <= k == 0; comp_b_hit <= k == 1; trigger_evt <= k == 2;
        @(posedge clock) {comp_a_hit, comp_b_hit, trigger_evt} <= 3'h0;
    endtask
    task conclude;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin #5000; error_cnt++; conclude; end
    initial begin
        repeat (20) @(posedge clock);
        arst_n <= 1; @(posedge clock);
        rs(32'h0);
        apb(1, 8'h04, 32'hff); chk({31'h0, err}, 32'h0);
        rs(32'h0);
        apb(0, 8'h08, 0); chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("register test done");
        apb(1, 8'h00, 32'hc0); rs(32'h20);
        pulse(0); rs(32'ha0);
        pulse(2); for (int i = 0; i < 40 && run_armed; i++) @(posedge clock);
        rs(32'h88);
        drain <= 1; repeat (3) @(posedge clock); drain <= 0;
        rs(32'h88);
        chk({28'h0, fifo_words}, 32'h5);
        $display("begin trace test done");
        apb(1, 8'h00, 32'he0); rs(32'h20);
        pulse(1); repeat (12) @(posedge clock); rs(32'h60);
        pulse(2); rs(32'h48);
        apb(1, 8'h00, 32'hc0); apb(1, 8'h00, 32'h40); rs(32'h0);
        apb(1, 8'h00, 32'hc0); apb(1, 8'h00, 32'h80); rs(32'h0);
        apb(0, 8'h00, 0); chk(rd, 32'h80);
        pulse(0); rs(32'h0);
        $display("end trace test done");
        conclude;
    end
endmodule // drs_debug_run_status_tb
bind drs_debug_run_status drs_chk drs_chk_inst (.clock(clock),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pslverr(pslverr), .trigger_evt(trigger_evt), .fifo_full(fifo_full),
    .fifo_capture(fifo_capture), .run_start(run_start),
    .run_armed(run_armed), .paddr(paddr), .prdata(prdata));
`default_nettype wire

// ==== bench/drs_fifo_model.sv ====
// Purpose: trace fifo stand-in. Assumes: one word a clock. Notes: drain = host
`timescale 1ns/1ps
`default_nettype none
module drs_fifo_model (input wire logic clock, arst_n, fifo_capture,
    input wire logic run_start, drain, output var logic [3:0] fifo_words,
    output wire logic fifo_full);
    assign fifo_full = fifo_words == 4'h8;
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) fifo_words <= 4'h0;
        else if (run_start) fifo_words <= 4'h0;
        else if (drain) fifo_words <= fifo_words - 4'h1;
        else if (fifo_capture && !fifo_full) fifo_words <= fifo_words + 4'h1;
    end
endmodule // drs_fifo_model
`default_nettype wire

// ==== design/drs_debug_run_status.v ====
// Purpose: debug run status and arm control behind an apb slave
// Assumes: comparator, trigger and fifo logic sit outside this block
// Notes:   zero-wait apb; read data captured in the setup cycle
`timescale 1ns/1ps
`default_nettype none
`include "drs_map.vh"

// How it works
// R1: the status register ignores every write.
// R2: bit 7 clears at run start and sets on a comparator A hit while armed.
// R3: bit 6 clears at run start and sets on a comparator B hit while armed.
// R4: bit 5 shows the arm control bit while the module is enabled.
// R5: writing arm while enabled starts a run; hardware clears arm at run end.
// R6: a run ends on fifo full in begin trace or on a trigger in end trace.
// R7: writing 0 to arm or enable ends the run at once and clears arm.
// R8: bits 3:0 clear at run start and hold the fifo word count at run end.
// R9: the captured count does not move while the host drains the fifo.
// R10: the host keeps its own count of fifo words left to read.
// R11: begin/end select picks begin or circular end trace; event-only is begin.
// R12: bit 4 of the status register reads as 0.
module drs_debug_run_status (
    input  wire                 clock,
    input  wire                 arst_n,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [`DRS_AW-1:0]   paddr,
    input  wire [31:0]          pwdata,
    output wire                 pready,
    output wire                 pslverr,
    output reg  [31:0]          prdata,
    input  wire                 comp_a_hit,
    input  wire                 comp_b_hit,
    input  wire                 trigger_evt,
    input  wire                 fifo_full,
    input  wire [`DRS_CNT_W-1:0] fifo_words,
    output wire                 fifo_capture,
    output wire                 run_start,
    output wire                 run_armed
);

    // control state
    reg                   enable_d;
    reg                   enable_q;
    reg                   arm_d;
    reg                   arm_q;
    reg                   end_sel_d;
    reg                   end_sel_q;
    reg                   evt_only_d;
    reg                   evt_only_q;

    // run state
    reg                   trig_seen_d;
    reg                   trig_seen_q;
    reg [`DRS_CNT_W-1:0]  cnt_d;
    reg [`DRS_CNT_W-1:0]  cnt_q;
    reg [31:0]            rdata_d;
    wire                  a_hit_q;
    wire                  b_hit_q;

    // apb decode
    wire                  setup;
    wire                  access;
    wire                  hit_ctl;
    wire                  hit_st;
    wire                  mapped;
    wire                  ctl_wr;
    wire                  rd_setup;
    wire                  new_en;
    wire                  new_arm;
    wire                  new_end;
    wire                  new_evt;

    // run control
    wire                  end_trace;
    wire                  armed;
    wire                  manual_end;
    wire                  auto_end;
    wire                  run_end;
    wire [`DRS_CNT_W-1:0] cnt_sat;
    wire [7:0]            ctl_image;
    wire [7:0]            st_image;

    assign setup    = psel & ~penable;
    assign access   = psel & penable;
    assign hit_ctl  = (paddr == `DRS_OFF_CTRL);
    assign hit_st   = (paddr == `DRS_OFF_STATUS);
    assign mapped   = hit_ctl | hit_st;
    // only the control word is writable; status writes decode to nothing
    assign ctl_wr   = access & pwrite & hit_ctl; // [R1]
    assign rd_setup = setup & ~pwrite;
    assign new_en   = pwdata[`DRS_CTL_EN_BIT];
    assign new_arm  = pwdata[`DRS_CTL_ARM_BIT];
    assign new_end  = pwdata[`DRS_CTL_END_BIT];
    assign new_evt  = pwdata[`DRS_CTL_EVT_BIT];

    // end trace only outside event-only modes
    assign end_trace  = end_sel_q & ~evt_only_q; // [R11]
    assign armed      = arm_q & enable_q;

    // a start needs an idle block, so start and end never coincide
    assign run_start  = ctl_wr & new_en & new_arm & ~armed; // [R5]
    assign manual_end = ctl_wr & armed & (~new_en | ~new_arm); // [R7]
    assign auto_end   = armed & (end_trace ? trigger_evt
                                           : fifo_full); // [R6]
    assign run_end    = manual_end | auto_end;

    // saturate: the fifo holds at most eight words
    assign cnt_sat    = (fifo_words > `DRS_CNT_MAX) ? `DRS_CNT_MAX
                                                    : fifo_words; // [R8]

    assign pready       = 1'b1;
    assign pslverr      = access & ~mapped;
    assign run_armed    = armed;
    // begin trace waits for the trigger, end trace fills circularly
    assign fifo_capture = armed & (end_trace | trig_seen_q
                                   | trigger_evt); // [R11]

    assign ctl_image = {enable_q, arm_q, end_sel_q, evt_only_q, 4'h0};
    assign st_image  = {a_hit_q, b_hit_q, armed, // [R4]
                        1'b0, cnt_q}; // [R12]

    // match flags share one cell; clear at start beats a same-cycle hit
    drs_hit_flag drs_hit_flag_a (
        .clock  (clock),
        .arst_n (arst_n),
        .clear  (run_start),
        .armed  (armed),
        .hit    (comp_a_hit),
        .flag_q (a_hit_q)
    ); // [R2]

    drs_hit_flag drs_hit_flag_b (
        .clock  (clock),
        .arst_n (arst_n),
        .clear  (run_start),
        .armed  (armed),
        .hit    (comp_b_hit),
        .flag_q (b_hit_q)
    ); // [R3]

    always @* begin
        enable_d    = enable_q;
        arm_d       = arm_q;
        end_sel_d   = end_sel_q;
        evt_only_d  = evt_only_q;
        trig_seen_d = trig_seen_q;
        cnt_d       = cnt_q;
        if (ctl_wr) begin
            enable_d   = new_en;
            arm_d      = new_en & new_arm; // [R5]
            end_sel_d  = new_end;
            evt_only_d = new_evt;
        end
        if (run_start) begin
            trig_seen_d = 1'b0;
            cnt_d       = `DRS_CNT_RESET; // [R8]
        end else begin
            if (armed & trigger_evt)
                trig_seen_d = 1'b1;
            // end beats a same-cycle rewrite of arm
            if (run_end) begin
                arm_d = 1'b0; // [R5] [R7]
                cnt_d = cnt_sat; // [R8]
            end
        end
        // count frozen otherwise, readout never touches it [R9]
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            enable_q   <= 1'b0;
            arm_q      <= 1'b0;
            end_sel_q  <= 1'b0;
            evt_only_q <= 1'b0;
        end else begin
            enable_q   <= enable_d;
            arm_q      <= arm_d;
            end_sel_q  <= end_sel_d;
            evt_only_q <= evt_only_d;
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trig_seen_q <= 1'b0;
            cnt_q       <= `DRS_CNT_RESET;
        end else begin
            trig_seen_q <= trig_seen_d;
            cnt_q       <= cnt_d;
        end
    end

    // read data registered in the setup cycle, so zero wait states
    always @* begin
        rdata_d = prdata;
        if (rd_setup) begin
            if (hit_ctl)
                rdata_d = {24'h00_0000, ctl_image};
            else if (hit_st)
                rdata_d = {24'h00_0000, st_image}; // [R4] [R12]
            else
                rdata_d = 32'h0000_0000;
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            prdata <= `DRS_RDATA_RESET;
        else
            prdata <= rdata_d;
    end

endmodule // drs_debug_run_status

// one match flag: cleared by a run start, set by a hit while armed
module drs_hit_flag (
    input  wire clock,
    input  wire arst_n,
    input  wire clear,
    input  wire armed,
    input  wire hit,
    output reg  flag_q
);

    reg flag_d;

    always @* begin
        flag_d = flag_q;
        if (clear)
            flag_d = 1'b0;
        else if (armed & hit)
            flag_d = 1'b1;
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

endmodule // drs_hit_flag
`default_nettype wire

// ==== design/drs_map.vh ====
// Purpose: constants for the debug run status block
// Assumes: 32-bit apb data, byte addresses, one word per register
// Notes:   control register offset and layout are local choices
`ifndef DRS_MAP_VH
`define DRS_MAP_VH
`define DRS_AW            8
`define DRS_OFF_CTRL      8'h00
`define DRS_OFF_STATUS    8'h04
// control register fields
`define DRS_CTL_EN_BIT    7
`define DRS_CTL_ARM_BIT   6
`define DRS_CTL_END_BIT   5
`define DRS_CTL_EVT_BIT   4
`define DRS_CTL_RESET     8'h00
// status register fields
`define DRS_ST_AHIT_BIT   7
`define DRS_ST_BHIT_BIT   6
`define DRS_ST_ARM_BIT    5
`define DRS_ST_CNT_MSB    3
`define DRS_ST_ZERO_BIT   4
`define DRS_RDATA_RESET   32'h0000_0000
`define DRS_CNT_W         4
`define DRS_CNT_MAX       4'h8
`define DRS_CNT_RESET     4'h0
`endif
